// ### rtl/pll_clock_config_pkg.sv
package pll_clock_config_pkg;

  // ==================================================
  // Register offsets
  localparam logic [7:0] ADDR_RESET_ID_LOW = 8'h00;
  localparam logic [7:0] ADDR_ID_HIGH = 8'h01;
  localparam logic [7:0] ADDR_REVISION = 8'h02;
  localparam logic [7:0] ADDR_FRAC_LOW = 8'h03;
  localparam logic [7:0] ADDR_FRAC_MID = 8'h04;
  localparam logic [7:0] ADDR_FRAC_HIGH = 8'h05;
  localparam logic [7:0] ADDR_INT_VALID = 8'h06;
  localparam logic [7:0] ADDR_DIV_CTRL = 8'h07;
  localparam logic [7:0] ADDR_CLK_SEL = 8'h08;

  // ==================================================
  // Reset values
  localparam logic [7:0] RST_FRAC_LOW = 8'h21;
  localparam logic [7:0] RST_FRAC_MID = 8'hfd;
  localparam logic [7:0] RST_FRAC_HIGH = 8'h36;
  localparam logic [7:0] RST_INT_VALID = 8'h07;
  localparam logic [7:0] RST_DIV_CTRL = 8'h16;
  localparam logic [7:0] RST_CLK_SEL = 8'h18;

  // ==================================================
  // Writable bit masks, and the revision read mask; other bits hold zero
  localparam logic [7:0] MASK_FRAC_HIGH = 8'h3f;
  localparam logic [7:0] MASK_DIV_CTRL = 8'h3f;
  localparam logic [7:0] MASK_CLK_SEL = 8'hf8;
  localparam logic [7:0] MASK_REVISION = 8'h0f;

  // ==================================================
  // Field positions, integer / validity register
  localparam int INT_LSB = 0;
  localparam int INT_MSB = 3;
  localparam int BIT_PLL_INPUT_HALVING = 4;
  localparam int BIT_TX_VALIDITY_SUB0 = 5;
  localparam int BIT_TX_VALIDITY_SUB1 = 6;
  localparam int BIT_TX_VALIDITY_FORCE = 7;
  // Divider control register
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int BIT_FRACTIONAL_PLL_ON = 2;
  localparam int BIT_MASTER_CLOCK_DIVIDER_SEL = 3;
  localparam int AUX_DIV_LSB = 4;
  localparam int AUX_DIV_MSB = 5;
  // Clock select register
  localparam int BIT_AUX_CLOCK_SOURCE = 3;
  localparam int BIT_AUX_CLOCK_PIN_ENABLE = 4;
  localparam int BIT_ERROR_FILL_SELECT = 5;
  localparam int BIT_IGNORE_INVALID_FLAG = 6;
  localparam int BIT_MASTER_CLOCK_SOURCE = 7;

  // ==================================================
  // Widths
  localparam int FRAC_W = 22;
  localparam int SAMPLE_W = 24;
  localparam int DIV_CNT_W = 3;

  // Receiver sample bundle
  typedef struct packed {
    logic strobe;
    logic [SAMPLE_W-1:0] data;
  } rx_sample_s;

  // Complete state of the register bank apart from the reset synchroniser
  typedef struct packed {
    logic [7:0] frac_low;
    logic [7:0] frac_mid;
    logic [7:0] frac_high;
    logic [7:0] int_valid;
    logic [7:0] div_ctrl;
    logic [7:0] clk_sel;
    logic [7:0] rdata;
    logic rvalid;
    logic soft_reset;
    logic xtal_q;
    logic one_q;
    logic two_q;
    logic [DIV_CNT_W-1:0] xtal_cnt;
    logic [DIV_CNT_W-1:0] one_cnt;
    logic [DIV_CNT_W-1:0] two_cnt;
    logic pll_input;
    logic aux_clk;
    logic aux_oe;
    logic master_clk;
    logic val0;
    logic val1;
    rx_sample_s rx;
    logic rx_invalid;
    logic [FRAC_W-1:0] frac_out;
    logic [3:0] int_out;
    logic frac_on;
    logic [1:0] mode_out;
  } state_s;

endpackage

// ### rtl/pll_clock_config_regs.sv
`timescale 1ns/1ps
module pll_clock_config_regs #(
  parameter logic [15:0] DEVICE_ID = 16'h5a3c, // Arbitrary value
  parameter logic [3:0] DEVICE_REVISION = 4'h1 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control interface register port
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output logic soft_reset_out,
  // Clock sources, sampled as levels
  input wire logic crystal_clock_in,
  input wire logic pll_clock_one_in,
  input wire logic pll_clock_two_in,
  // PLL settings
  output logic pll_input_out,
  output logic [pll_clock_config_pkg::FRAC_W-1:0] pll_fraction_out,
  output logic [3:0] pll_integer_out,
  output logic fractional_pll_on_out,
  output logic [1:0] pll_post_divider_mode_out,
  input wire logic spdif_rx_mode_in,
  input wire logic [1:0] rx_post_divider_mode_in,
  // Clock outputs
  output logic master_clock_out,
  output logic aux_clock_pin_out,
  output logic aux_clock_pin_oe_out,
  // Transmit validity
  input wire logic tx_source_is_rx_in,
  input wire logic rx_validity_in,
  output logic tx_validity_sub0_out,
  output logic tx_validity_sub1_out,
  // Receiver samples
  input wire logic rx_sample_strobe_in,
  input wire logic [pll_clock_config_pkg::SAMPLE_W-1:0] rx_sample_in,
  input wire logic rx_error_in,
  input wire logic rx_invalid_flag_in,
  output logic rx_sample_strobe_out,
  output logic [pll_clock_config_pkg::SAMPLE_W-1:0] rx_sample_out,
  output logic rx_invalid_out
);

  // ==================================================
  // Helpers
  // Tap of an edge counter: sel 0 passes source, n gives divide by 2^n
  function automatic logic div_tap(input logic src, input logic [2:0] cnt, input logic [1:0] sel);
    logic r;
    r = src;
    case (sel)
      2'h1: r = cnt[0];
      2'h2: r = cnt[1];
      2'h3: r = cnt[2];
      default: r = src;
    endcase
    return r;
  endfunction

  // ==================================================
  // Reset synchroniser
  logic [1:0] rst_sync_ff; // Two-stage release
  logic rst_n; // Synchronised reset

  // Async assert, sync release
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ==================================================
  // State
  pll_clock_config_pkg::state_s st_ff; // All registered state except the reset synchroniser
  pll_clock_config_pkg::state_s nxt_st; // Next state
  logic bad_sample; // Current sample is unusable

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'h0;
    nxt_st.soft_reset = 1'h0;
    nxt_st.rx.strobe = 1'h0;
    bad_sample = rx_error_in | (rx_invalid_flag_in & ~st_ff.clk_sel[pll_clock_config_pkg::BIT_IGNORE_INVALID_FLAG]);

    // Register writes; a write to the reset address restores defaults
    if (st_ff.soft_reset) begin
      nxt_st.frac_low = pll_clock_config_pkg::RST_FRAC_LOW;
      nxt_st.frac_mid = pll_clock_config_pkg::RST_FRAC_MID;
      nxt_st.frac_high = pll_clock_config_pkg::RST_FRAC_HIGH;
      nxt_st.int_valid = pll_clock_config_pkg::RST_INT_VALID;
      nxt_st.div_ctrl = pll_clock_config_pkg::RST_DIV_CTRL;
      nxt_st.clk_sel = pll_clock_config_pkg::RST_CLK_SEL;
    end else if (wr_en_in) begin
      case (addr_in)
        pll_clock_config_pkg::ADDR_RESET_ID_LOW: begin
          nxt_st.soft_reset = 1'h1;
        end
        pll_clock_config_pkg::ADDR_FRAC_LOW: begin
          nxt_st.frac_low = wdata_in;
        end
        pll_clock_config_pkg::ADDR_FRAC_MID: begin
          nxt_st.frac_mid = wdata_in;
        end
        pll_clock_config_pkg::ADDR_FRAC_HIGH: begin
          nxt_st.frac_high = wdata_in & pll_clock_config_pkg::MASK_FRAC_HIGH;
        end
        pll_clock_config_pkg::ADDR_INT_VALID: begin
          nxt_st.int_valid = wdata_in;
        end
        pll_clock_config_pkg::ADDR_DIV_CTRL: begin
          nxt_st.div_ctrl = wdata_in & pll_clock_config_pkg::MASK_DIV_CTRL;
        end
        pll_clock_config_pkg::ADDR_CLK_SEL: begin
          nxt_st.clk_sel = wdata_in & pll_clock_config_pkg::MASK_CLK_SEL;
        end
        default: begin
          // Read-only and unmapped addresses ignore writes
        end
      endcase
    end

    // Receive mode takes over the post-divider field; hardware wins over register writes but not over a soft reset
    if (spdif_rx_mode_in && !st_ff.soft_reset) begin
      nxt_st.div_ctrl[pll_clock_config_pkg::MODE_MSB:pll_clock_config_pkg::MODE_LSB] = rx_post_divider_mode_in;
    end

    // Register reads; answer one cycle after the request
    if (rd_en_in) begin
      nxt_st.rvalid = 1'h1;
      case (addr_in)
        pll_clock_config_pkg::ADDR_RESET_ID_LOW: nxt_st.rdata = DEVICE_ID[7:0];
        pll_clock_config_pkg::ADDR_ID_HIGH: nxt_st.rdata = DEVICE_ID[15:8];
        pll_clock_config_pkg::ADDR_REVISION: nxt_st.rdata = {4'h0, DEVICE_REVISION} & pll_clock_config_pkg::MASK_REVISION;
        pll_clock_config_pkg::ADDR_FRAC_LOW: nxt_st.rdata = st_ff.frac_low;
        pll_clock_config_pkg::ADDR_FRAC_MID: nxt_st.rdata = st_ff.frac_mid;
        pll_clock_config_pkg::ADDR_FRAC_HIGH: nxt_st.rdata = st_ff.frac_high;
        pll_clock_config_pkg::ADDR_INT_VALID: nxt_st.rdata = st_ff.int_valid;
        pll_clock_config_pkg::ADDR_DIV_CTRL: nxt_st.rdata = st_ff.div_ctrl;
        pll_clock_config_pkg::ADDR_CLK_SEL: nxt_st.rdata = st_ff.clk_sel;
        default: nxt_st.rdata = 8'h00; // Unmapped reads as zero
      endcase
    end

    // Edge counters on the sampled clock sources
    nxt_st.xtal_q = crystal_clock_in;
    nxt_st.one_q = pll_clock_one_in;
    nxt_st.two_q = pll_clock_two_in;
    if (crystal_clock_in && !st_ff.xtal_q) begin
      nxt_st.xtal_cnt = st_ff.xtal_cnt + 3'h1;
    end
    if (pll_clock_one_in && !st_ff.one_q) begin
      nxt_st.one_cnt = st_ff.one_cnt + 3'h1;
    end
    if (pll_clock_two_in && !st_ff.two_q) begin
      nxt_st.two_cnt = st_ff.two_cnt + 3'h1;
    end

    // PLL input: crystal, or crystal halved
    nxt_st.pll_input = st_ff.int_valid[pll_clock_config_pkg::BIT_PLL_INPUT_HALVING] ?
                       st_ff.xtal_cnt[0] : crystal_clock_in;

    // Master clock: crystal, or clock two with its optional halving
    if (st_ff.clk_sel[pll_clock_config_pkg::BIT_MASTER_CLOCK_SOURCE]) begin
      nxt_st.master_clk = crystal_clock_in;
    end else begin
      nxt_st.master_clk = div_tap(pll_clock_two_in, st_ff.two_cnt,
                                  {1'h0, st_ff.div_ctrl[pll_clock_config_pkg::BIT_MASTER_CLOCK_DIVIDER_SEL]});
    end

    // Aux pin: crystal, or clock one through its divider
    if (st_ff.clk_sel[pll_clock_config_pkg::BIT_AUX_CLOCK_SOURCE]) begin
      nxt_st.aux_clk = crystal_clock_in;
    end else begin
      nxt_st.aux_clk = div_tap(pll_clock_one_in, st_ff.one_cnt,
                               st_ff.div_ctrl[pll_clock_config_pkg::AUX_DIV_MSB:pll_clock_config_pkg::AUX_DIV_LSB]);
    end
    nxt_st.aux_oe = st_ff.clk_sel[pll_clock_config_pkg::BIT_AUX_CLOCK_PIN_ENABLE];

    // Transmit validity
    if (st_ff.int_valid[pll_clock_config_pkg::BIT_TX_VALIDITY_FORCE]) begin
      nxt_st.val0 = st_ff.int_valid[pll_clock_config_pkg::BIT_TX_VALIDITY_SUB0];
      nxt_st.val1 = st_ff.int_valid[pll_clock_config_pkg::BIT_TX_VALIDITY_SUB1];
    end else begin
      nxt_st.val0 = tx_source_is_rx_in & rx_validity_in;
      nxt_st.val1 = tx_source_is_rx_in & rx_validity_in;
    end

    // Receiver samples: good ones pass, bad ones hold or become zero
    nxt_st.rx_invalid = rx_invalid_flag_in & ~st_ff.clk_sel[pll_clock_config_pkg::BIT_IGNORE_INVALID_FLAG];
    if (rx_sample_strobe_in) begin
      nxt_st.rx.strobe = 1'h1;
      if (!bad_sample) begin
        nxt_st.rx.data = rx_sample_in;
      end else if (st_ff.clk_sel[pll_clock_config_pkg::BIT_ERROR_FILL_SELECT]) begin
        nxt_st.rx.data = '0;
      end
    end

    // PLL ratio: fraction only counts in fractional mode
    nxt_st.int_out = st_ff.int_valid[pll_clock_config_pkg::INT_MSB:pll_clock_config_pkg::INT_LSB];
    nxt_st.frac_on = st_ff.div_ctrl[pll_clock_config_pkg::BIT_FRACTIONAL_PLL_ON];
    nxt_st.frac_out = nxt_st.frac_on ?
                      {st_ff.frac_high[5:0], st_ff.frac_mid, st_ff.frac_low} : '0;
    nxt_st.mode_out = st_ff.div_ctrl[pll_clock_config_pkg::MODE_MSB:pll_clock_config_pkg::MODE_LSB];
  end

  // State register; defaults mirror a soft reset
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.frac_low <= pll_clock_config_pkg::RST_FRAC_LOW;
      st_ff.frac_mid <= pll_clock_config_pkg::RST_FRAC_MID;
      st_ff.frac_high <= pll_clock_config_pkg::RST_FRAC_HIGH;
      st_ff.int_valid <= pll_clock_config_pkg::RST_INT_VALID;
      st_ff.div_ctrl <= pll_clock_config_pkg::RST_DIV_CTRL;
      st_ff.clk_sel <= pll_clock_config_pkg::RST_CLK_SEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==================================================
  // Outputs, straight from the state register
  assign rdata_out = st_ff.rdata;
  assign rdata_valid_out = st_ff.rvalid;
  assign soft_reset_out = st_ff.soft_reset;
  assign pll_input_out = st_ff.pll_input;
  assign pll_fraction_out = st_ff.frac_out;
  assign pll_integer_out = st_ff.int_out;
  assign fractional_pll_on_out = st_ff.frac_on;
  assign pll_post_divider_mode_out = st_ff.mode_out;
  assign master_clock_out = st_ff.master_clk;
  assign aux_clock_pin_out = st_ff.aux_clk;
  assign aux_clock_pin_oe_out = st_ff.aux_oe;
  assign tx_validity_sub0_out = st_ff.val0;
  assign tx_validity_sub1_out = st_ff.val1;
  assign rx_sample_strobe_out = st_ff.rx.strobe;
  assign rx_sample_out = st_ff.rx.data;
  assign rx_invalid_out = st_ff.rx_invalid;

  // ==================================================
  // Assertions
  property p_reset_write;
    @(posedge clk_in) disable iff (!rst_n)
    wr_en_in && addr_in == pll_clock_config_pkg::ADDR_RESET_ID_LOW |=> soft_reset_out ##1
      (st_ff.int_valid == pll_clock_config_pkg::RST_INT_VALID && st_ff.clk_sel == pll_clock_config_pkg::RST_CLK_SEL);
  endproperty
  a_reset_write: assert property (p_reset_write) else $error("soft reset did not restore defaults");

  property p_id_read;
    @(posedge clk_in) disable iff (!rst_n)
    rd_en_in && addr_in == pll_clock_config_pkg::ADDR_ID_HIGH |=> rdata_valid_out && rdata_out == DEVICE_ID[15:8];
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity high byte wrong");

  property p_fraction;
    @(posedge clk_in) disable iff (!rst_n)
    st_ff.div_ctrl[pll_clock_config_pkg::BIT_FRACTIONAL_PLL_ON] |=>
      pll_fraction_out == {$past(st_ff.frac_high[5:0]), $past(st_ff.frac_mid), $past(st_ff.frac_low)};
  endproperty
  a_fraction: assert property (p_fraction) else $error("fraction assembly wrong");

  property p_frac_off;
    @(posedge clk_in) disable iff (!rst_n)
    !st_ff.div_ctrl[pll_clock_config_pkg::BIT_FRACTIONAL_PLL_ON] |=>
      pll_fraction_out == '0 && !fractional_pll_on_out;
  endproperty
  a_frac_off: assert property (p_frac_off) else $error("fraction not ignored in integer mode");

  property p_validity_free;
    @(posedge clk_in) disable iff (!rst_n)
    !st_ff.int_valid[pll_clock_config_pkg::BIT_TX_VALIDITY_FORCE] |=>
      tx_validity_sub0_out == ($past(tx_source_is_rx_in) & $past(rx_validity_in));
  endproperty
  a_validity_free: assert property (p_validity_free) else $error("unforced validity wrong");

  property p_validity_force;
    @(posedge clk_in) disable iff (!rst_n)
    st_ff.int_valid[pll_clock_config_pkg::BIT_TX_VALIDITY_FORCE] |=>
      tx_validity_sub1_out == $past(st_ff.int_valid[pll_clock_config_pkg::BIT_TX_VALIDITY_SUB1]);
  endproperty
  a_validity_force: assert property (p_validity_force) else $error("forced validity wrong");

  property p_aux_enable;
    @(posedge clk_in) disable iff (!rst_n)
    aux_clock_pin_oe_out |-> $past(st_ff.clk_sel[pll_clock_config_pkg::BIT_AUX_CLOCK_PIN_ENABLE]);
  endproperty
  a_aux_enable: assert property (p_aux_enable) else $error("aux pin driven while disabled");

  property p_master_xtal;
    @(posedge clk_in) disable iff (!rst_n)
    st_ff.clk_sel[pll_clock_config_pkg::BIT_MASTER_CLOCK_SOURCE] |=> master_clock_out == $past(crystal_clock_in);
  endproperty
  a_master_xtal: assert property (p_master_xtal) else $error("master clock not crystal");

  property p_fill_zero;
    @(posedge clk_in) disable iff (!rst_n)
    rx_sample_strobe_in && rx_error_in && st_ff.clk_sel[pll_clock_config_pkg::BIT_ERROR_FILL_SELECT] |=>
      rx_sample_strobe_out && rx_sample_out == '0;
  endproperty
  a_fill_zero: assert property (p_fill_zero) else $error("bad sample not zero filled");

  property p_rx_mode;
    @(posedge clk_in) disable iff (!rst_n)
    spdif_rx_mode_in && !soft_reset_out |=>
      st_ff.div_ctrl[pll_clock_config_pkg::MODE_MSB:pll_clock_config_pkg::MODE_LSB] ==
      $past(rx_post_divider_mode_in);
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("receive mode did not set post divider");

  // Aux pin follows the crystal whenever the source bit picks it, divider or not
  property p_aux_xtal;
    @(posedge clk_in) disable iff (!rst_n)
    st_ff.clk_sel[pll_clock_config_pkg::BIT_AUX_CLOCK_SOURCE] |=> aux_clock_pin_out == $past(crystal_clock_in);
  endproperty
  a_aux_xtal: assert property (p_aux_xtal) else $error("aux pin not crystal");

  // With the ignore bit set, no invalid indication may leave the block
  property p_ignore_invalid;
    @(posedge clk_in) disable iff (!rst_n)
    st_ff.clk_sel[pll_clock_config_pkg::BIT_IGNORE_INVALID_FLAG] |=> !rx_invalid_out;
  endproperty
  a_ignore_invalid: assert property (p_ignore_invalid) else $error("invalid flag not ignored");

  c_soft_reset: cover property (@(posedge clk_in) disable iff (!rst_n) soft_reset_out);
  c_fill_hold: cover property (@(posedge clk_in) disable iff (!rst_n)
    rx_sample_strobe_in && rx_error_in && !st_ff.clk_sel[5]);
  c_forced_validity: cover property (@(posedge clk_in) disable iff (!rst_n) st_ff.int_valid[7] && tx_validity_sub0_out);
  c_aux_divided: cover property (@(posedge clk_in) disable iff (!rst_n) !st_ff.clk_sel[3] && st_ff.div_ctrl[5:4] == 2'h3);

endmodule

// ### verif/host_model.sv
`timescale 1ns/1ps
// ==================================================
// Host controller on the register port
module host_model (
  // Clock
  input wire logic clk_in,
  // Register port towards the device
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  // Read answer from the device
  input wire logic [7:0] rdata_in,
  input wire logic rdata_valid_in
);
  // Idle until the first request
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // One write, held across exactly one taking edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    addr_out = addr;
    wdata_out = data;
    wr_en_out = 1'b1;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    // Released lines show the inverse, so a stale value never looks fresh
    addr_out = ~addr;
    wdata_out = ~data;
  endtask

  // One read; the answer is a one-cycle pulse, caught half a cycle later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clk_in);
    addr_out = addr;
    rd_en_out = 1'b1;
    @(negedge clk_in);
    rd_en_out = 1'b0;
    addr_out = ~addr;
    ok = rdata_valid_in;
    data = rdata_in;
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
// ==================================================
// Self-checking bench for the PLL and clock register bank
module tb;
  localparam logic [15:0] ID = 16'hc3e1; // Arbitrary value
  localparam logic [3:0] REV = 4'h9; // Arbitrary value
  // Stimulus
  logic clk_in = 1'b0; // Starts low, so time zero brings no false falling edge to the source toggles
  logic resetn_in, xtal, one, two, rx_mode, src_rx, rx_val, strb, err, inv;
  logic [1:0] rx_div;
  logic [23:0] sample;
  // Observed outputs and host wires
  logic wr_en, rd_en, rvalid, srst, pll_in, frac_on, mclk, aux, aux_oe, v0, v1, strb_o, inv_o, ok;
  logic [7:0] addr, wdata, rdata, rd;
  logic [21:0] frac;
  logic [3:0] pint;
  logic [1:0] mode;
  logic [23:0] samp_o;
  int failures, comparisons, cycles, n;
  // Register rows: address, write data, read-back
  logic [23:0] rows [9] = '{{8'h03, 8'ha5, 8'ha5}, {8'h04, 8'h5a, 8'h5a}, {8'h05, 8'hff, 8'h3f},
    {8'h07, 8'hd6, 8'h16}, {8'h08, 8'hff, 8'hf8}, {8'h06, 8'h8c, 8'h8c}, {8'h01, 8'h12, ID[15:8]},
    {8'h02, 8'h34, {4'h0, REV}}, {8'h20, 8'h55, 8'h00}};
  // Clock rows: divider reg, select reg, master and aux changes per 16 cycles
  logic [31:0] ctab [4] = '{{8'h3e, 8'h90, 8'd16, 8'd2}, {8'h3e, 8'h18, 8'd8, 8'd16},
    {8'h06, 8'h10, 8'd16, 8'd16}, {8'h16, 8'h10, 8'd16, 8'd8}};
  // Validity rows: reg value, source is receiver, received bit, sub0, sub1
  logic [11:0] vtab [5] = '{{8'h08, 4'b0100}, {8'h08, 4'b1111}, {8'h08, 4'b1000},
    {8'ha8, 4'b1010}, {8'hc8, 4'b0101}};

  pll_clock_config_regs #(.DEVICE_ID(ID), .DEVICE_REVISION(REV)) pll_clock_config_regs_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata), .rdata_valid_out(rvalid), .soft_reset_out(srst),
    .crystal_clock_in(xtal), .pll_clock_one_in(one), .pll_clock_two_in(two), .pll_input_out(pll_in),
    .pll_fraction_out(frac), .pll_integer_out(pint), .fractional_pll_on_out(frac_on),
    .pll_post_divider_mode_out(mode), .spdif_rx_mode_in(rx_mode), .rx_post_divider_mode_in(rx_div),
    .master_clock_out(mclk), .aux_clock_pin_out(aux), .aux_clock_pin_oe_out(aux_oe),
    .tx_source_is_rx_in(src_rx), .rx_validity_in(rx_val), .tx_validity_sub0_out(v0),
    .tx_validity_sub1_out(v1), .rx_sample_strobe_in(strb), .rx_sample_in(sample), .rx_error_in(err),
    .rx_invalid_flag_in(inv), .rx_sample_strobe_out(strb_o), .rx_sample_out(samp_o),
    .rx_invalid_out(inv_o));

  host_model host_model_inst (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .wdata_out(wdata), .rdata_in(rdata), .rdata_valid_in(rvalid));

  // ==================================================
  // Clock and source clocks; sources toggle every cycle
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    xtal <= ~xtal;
    one <= ~one;
    two <= ~two;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      end_sim();
    end
  end

  // ==================================================
  // Checking helpers
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.read_reg(a, rd, ok);
    chk("read valid", 24'h1, {23'h0, ok});
    chk("read data", {16'h0, exp}, {16'h0, rd});
  endtask
  // Counts level changes of one clock output over a 16-cycle window
  task automatic count(input int sel, output int c);
    logic last;
    logic now;
    c = 0;
    repeat (4) @(negedge clk_in);
    last = (sel == 0) ? mclk : (sel == 1) ? aux : pll_in;
    repeat (16) begin
      @(negedge clk_in);
      now = (sel == 0) ? mclk : (sel == 1) ? aux : pll_in;
      if (now !== last) c++;
      last = now;
    end
  endtask
  // One receiver sample, answer looked at in its single strobe cycle
  task automatic rx(input logic [23:0] d, input logic e, input logic i, input logic [23:0] xd, input logic xi);
    @(negedge clk_in);
    sample = d;
    err = e;
    inv = i;
    strb = 1'b1;
    @(negedge clk_in);
    strb = 1'b0;
    chk("rx strobe", 24'h1, {23'h0, strb_o});
    chk("rx data", xd, samp_o);
    chk("rx invalid", {23'h0, xi}, {23'h0, inv_o});
  endtask
  task automatic end_sim();
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==================================================
  // Main sequence
  initial begin
    {resetn_in, xtal, one, two, rx_mode, src_rx, rx_val, strb, err, inv} = '0;
    {rx_div, sample, failures, comparisons, cycles} = '0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    // Defaults after power-on reset
    chk("fraction", 24'h36fd21, {2'h0, frac});
    chk("integer", 24'h7, {20'h0, pint});
    chk("mode", 24'h2, {22'h0, mode});
    chk("aux enable", 24'h1, {23'h0, aux_oe});
    rd_chk(8'h00, ID[7:0]);
    // Ordinary rows: write, then read back
    foreach (rows[i]) begin
      host_model_inst.write_reg(rows[i][23:16], rows[i][15:8]);
      rd_chk(rows[i][23:16], rows[i][7:0]);
    end
    repeat (2) @(negedge clk_in);
    chk("fraction", 24'h3f5aa5, {2'h0, frac});
    host_model_inst.write_reg(8'h07, 8'h12);
    repeat (3) @(negedge clk_in);
    chk("fraction off", 24'h0, {2'h0, frac});
    chk("frac mode", 24'h0, {23'h0, frac_on});
    // Soft reset by any write to address zero
    host_model_inst.write_reg(8'h00, 8'h00);
    n = 0;
    repeat (4) begin
      n += int'(srst === 1'b1);
      @(negedge clk_in);
    end
    chk("soft reset pulses", 24'h1, 24'(n));
    rd_chk(8'h08, 8'h18);
    rd_chk(8'h03, 8'h21);
    rd_chk(8'h07, 8'h16);
    // Receive mode takes over the mode field; fraction kept on for it
    host_model_inst.write_reg(8'h06, 8'h08);
    rx_div = 2'h1;
    rx_mode = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("rx mode field", 24'h1, {22'h0, mode});
    chk("rx integer", 24'h8, {20'h0, pint});
    rx_mode = 1'b0;
    // Clock routing and dividers
    foreach (ctab[i]) begin
      host_model_inst.write_reg(8'h07, ctab[i][31:24]);
      host_model_inst.write_reg(8'h08, ctab[i][23:16]);
      count(0, n);
      chk("master changes", {16'h0, ctab[i][15:8]}, 24'(n));
      count(1, n);
      chk("aux changes", {16'h0, ctab[i][7:0]}, 24'(n));
    end
    host_model_inst.write_reg(8'h08, 8'h08);
    repeat (3) @(negedge clk_in);
    chk("aux enable", 24'h0, {23'h0, aux_oe});
    // Prescaler; integer part 8 sits in the preferred range
    host_model_inst.write_reg(8'h06, 8'h18);
    count(2, n);
    chk("pll input changes", 24'd8, 24'(n));
    chk("integer", 24'h8, {20'h0, pint});
    host_model_inst.write_reg(8'h06, 8'h08);
    count(2, n);
    chk("pll input changes", 24'd16, 24'(n));
    // Transmit validity, forced and unforced
    foreach (vtab[i]) begin
      host_model_inst.write_reg(8'h06, vtab[i][11:4]);
      src_rx = vtab[i][3];
      rx_val = vtab[i][2];
      repeat (3) @(negedge clk_in);
      chk("validity sub0", {23'h0, vtab[i][1]}, {23'h0, v0});
      chk("validity sub1", {23'h0, vtab[i][0]}, {23'h0, v1});
    end
    // Receiver fill and invalid handling
    host_model_inst.write_reg(8'h08, 8'h18);
    rx(24'h123456, 1'b0, 1'b0, 24'h123456, 1'b0);
    rx(24'habcdef, 1'b1, 1'b0, 24'h123456, 1'b0);
    rx(24'h111111, 1'b0, 1'b1, 24'h123456, 1'b1);
    host_model_inst.write_reg(8'h08, 8'h38);
    rx(24'h222222, 1'b1, 1'b0, 24'h000000, 1'b0);
    rx(24'h444444, 1'b0, 1'b1, 24'h000000, 1'b1);
    host_model_inst.write_reg(8'h08, 8'h78);
    rx(24'h333333, 1'b0, 1'b1, 24'h333333, 1'b0);
    end_sim();
  end
endmodule
